// ---- hdl/fdc_glue_pkg.sv ----
// Purpose: Constants for the floppy board address decoder and clock generator
// Assumes: 16-bit processor address bus, 16 MHz reference clock
// Notes:   Notes on behaviour list below
//
// Notes on behaviour
// RULE1 - RAM select when A15..A11 all low
// RULE2 - ROM select when A15..A12 all high
// RULE3 - Output byte clock at data location, unqualified
// RULE4 - Input byte enable at data, phase high, direction low
// RULE5 - Output driver enable on busy and direction high
// RULE6 - Status enable on read, phase high, 0800
// RULE7 - Command clock on write, phase high, 0800
// RULE8 - Last byte line at 0803 during phase high
// RULE9 - Disk chip select at 0804/0805 during phase
// RULE10 - Read strobe when direction high and phase high
// RULE11 - Write strobe when direction low and phase high
// RULE12 - All timing from one 16 MHz reference
// RULE13 - Divider halvings 8 MHz down to 250 kHz
// RULE14 - Mux selects by density and drive size
// RULE15 - Double density small drive: 4 MHz, 500 kHz
// RULE16 - Write clock 250 ns pulse at mux rate (code: WCLK_PULSE_CYCLES = 12 cycles of 20 ns, 240 ns)
// RULE17 - Disk chip interrupt passes to processor
// RULE18 - Terminal count ends read, then interrupt follows
// RULE19 - Separator splits read stream into clock, data
// RULE20 - Direction low means controller sends to host
// RULE21 - Decoded selects and strobes are active low
package fdc_glue_pkg;

	localparam logic [15:0] HOST_CMD_STAT_ADDR  = 16'h0800;
	localparam logic [15:0] HOST_BYTE_ADDR      = 16'h0801;
	localparam logic [15:0] LAST_BYTE_ADDR      = 16'h0803;
	localparam logic [15:0] DISK_CTRL_ADDR      = 16'h0804;
	localparam logic [15:0] DISK_STAT_ADDR      = 16'h0805;
	localparam int          REF_CLOCK_KHZ       = 16000;
	localparam int          CLOCK_PERIOD_NS     = 20;
	localparam int          WCLK_PULSE_NS       = 250;
	localparam int          WCLK_PULSE_CYCLES   = WCLK_PULSE_NS / CLOCK_PERIOD_NS;
	localparam int          DIV_TAPS            = 6;
	localparam int          SEP_WINDOW_CYCLES   = 12;

endpackage

// ---- hdl/fdc_clock_divider.sv ----
// Purpose: Binary divider of the 16 MHz reference enable into halving taps
// Assumes: i_ref_tick is a one-cycle pulse at the reference rate
// Notes:   Tap k toggles at ref / 2^(k+1), a square wave in the core clock
`timescale 1ns/1ps
module fdc_clock_divider #(
	parameter int TAPS = 6
) (
	// Clock and control
	input  wire logic            i_clk,
	input  wire logic            i_rst_n,
	input  wire logic            i_ce,
	input  wire logic            i_ref_tick,
	// Taps
	output logic [TAPS-1:0]      o_taps
);

	initial begin
		if (TAPS < 1 || TAPS > 16) begin
			$error("TAPS out of range");
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_taps <= '0;
		end else if (i_ce && i_ref_tick) begin
			o_taps <= o_taps + {{(TAPS-1){1'b0}}, 1'b1}; // [RULE13]
		end
	end

endmodule

// ---- hdl/fdc_board_glue.sv ----
// Purpose: Address decoder, clock generator and read data separator of the floppy board
// Assumes: Processor bus and board pins are asynchronous and pass two flip-flops
// Notes:   All decoded outputs are registered and active low
`timescale 1ns/1ps
module fdc_board_glue
	import fdc_glue_pkg::*;
#(
	parameter int REF_DIV = 3
) (
	// Clock, reset, enable
	input  wire logic        I_CLOCK,
	input  wire logic        I_RST_N,
	input  wire logic        I_CE,
	// Processor bus
	input  wire logic [15:0] I_ADDR,
	input  wire logic        I_CPU_READ,
	input  wire logic        I_CPU_PHASE_B,
	// Host bus lines
	input  wire logic        I_HOST_BUSY,
	input  wire logic        I_HOST_TO_DEV,
	// Disk chip and drive straps
	input  wire logic        I_DOUBLE_DENSITY_SEL,
	input  wire logic        I_SMALL_DRIVE_SEL_N,
	input  wire logic        I_DISK_CHIP_IRQ,
	input  wire logic        I_READ_STREAM,
	// Decoded selects and strobes
	output logic             O_RAM_SELECT_N,
	output logic             O_ROM_SELECT_N,
	output logic             O_OUT_BYTE_CLOCK_N,
	output logic             O_IN_BYTE_ENABLE_N,
	output logic             O_OUT_DRIVER_ENABLE_N,
	output logic             O_HOST_STAT_ENABLE_N,
	output logic             O_HOST_CMD_CLOCK_N,
	output logic             O_LAST_BYTE_N,
	output logic             O_DISK_CHIP_SELECT_N,
	output logic             O_READ_N,
	output logic             O_WRITE_N,
	output logic             O_CPU_IRQ_N,
	// Clock generator
	output logic             O_REF_CLOCK,
	output logic             O_CHIP_CLOCK,
	output logic             O_WCLK_SOURCE,
	output logic             O_WRITE_CLOCK_PULSE,
	// Data separator
	output logic             O_SEP_CLOCK,
	output logic             O_SEP_DATA
);

	initial begin
		if (REF_DIV < 1 || REF_DIV > 15) begin
			$error("REF_DIV out of range");
		end
	end

	// Synchronisers
	logic [15:0] addr_meta;
	logic [15:0] addr;
	logic [7:0]  pins_meta;
	logic [7:0]  pins;
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			addr_meta <= 16'h0000;
			addr      <= 16'h0000;
			pins_meta <= 8'h00;
			pins      <= 8'h00;
		end else if (I_CE) begin
			addr_meta <= I_ADDR;
			addr      <= addr_meta;
			pins_meta <= {I_CPU_PHASE_B, I_READ_STREAM, I_DISK_CHIP_IRQ, I_SMALL_DRIVE_SEL_N,
				I_DOUBLE_DENSITY_SEL, I_HOST_TO_DEV, I_HOST_BUSY, I_CPU_READ};
			pins      <= pins_meta;
		end
	end

	logic cpu_read;
	logic host_busy;
	logic host_to_dev;
	logic dbl_density;
	logic small_drive_n;
	logic chip_irq;
	logic read_stream;
	logic phase_b;
	assign cpu_read      = pins[0];
	assign host_busy     = pins[1];
	assign host_to_dev   = pins[2];
	assign dbl_density   = pins[3];
	assign small_drive_n = pins[4];
	assign chip_irq      = pins[5];
	assign read_stream   = pins[6];
	assign phase_b       = pins[7];

	function automatic logic addr_is(input logic [15:0] a, input logic [15:0] loc);
		addr_is = (a == loc);
	endfunction

	// Address decoder, low-true registered outputs
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			O_RAM_SELECT_N        <= 1'b1;
			O_ROM_SELECT_N        <= 1'b1;
			O_OUT_BYTE_CLOCK_N    <= 1'b1;
			O_IN_BYTE_ENABLE_N    <= 1'b1;
			O_OUT_DRIVER_ENABLE_N <= 1'b1;
			O_HOST_STAT_ENABLE_N  <= 1'b1;
			O_HOST_CMD_CLOCK_N    <= 1'b1;
			O_LAST_BYTE_N         <= 1'b1;
			O_DISK_CHIP_SELECT_N  <= 1'b1;
			O_READ_N              <= 1'b1;
			O_WRITE_N             <= 1'b1;
		end else if (I_CE) begin
			O_RAM_SELECT_N        <= !(addr[15:11] == 5'h00); // [RULE1] [RULE21]
			O_ROM_SELECT_N        <= !(addr[15:12] == 4'hf); // [RULE2] [RULE21]
			O_OUT_BYTE_CLOCK_N    <= !addr_is(addr, HOST_BYTE_ADDR); // [RULE3]
			O_IN_BYTE_ENABLE_N    <= !(addr_is(addr, HOST_BYTE_ADDR) && phase_b && !host_to_dev); // [RULE4] [RULE20]
			O_OUT_DRIVER_ENABLE_N <= !(host_busy && host_to_dev); // [RULE5] [RULE20]
			O_HOST_STAT_ENABLE_N  <= !(addr_is(addr, HOST_CMD_STAT_ADDR) && phase_b && cpu_read); // [RULE6]
			O_HOST_CMD_CLOCK_N    <= !(addr_is(addr, HOST_CMD_STAT_ADDR) && phase_b && !cpu_read); // [RULE7]
			O_LAST_BYTE_N         <= !(addr_is(addr, LAST_BYTE_ADDR) && phase_b); // [RULE8] [RULE18]
			O_DISK_CHIP_SELECT_N  <= !((addr_is(addr, DISK_CTRL_ADDR) || addr_is(addr, DISK_STAT_ADDR))
				&& phase_b); // [RULE9]
			O_READ_N              <= !(cpu_read && phase_b); // [RULE10]
			O_WRITE_N             <= !(!cpu_read && phase_b); // [RULE11]
		end
	end

	// Interrupt from the disk chip to the processor
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			O_CPU_IRQ_N <= 1'b1;
		end else if (I_CE) begin
			O_CPU_IRQ_N <= !chip_irq; // [RULE17] [RULE18]
		end
	end

	// Reference tick: 16 MHz approximated from the core clock by a fractional accumulator
	logic [15:0] ref_acc;
	logic        ref_tick;
	logic [16:0] next_ref_acc;
	always_comb begin
		next_ref_acc = {1'b0, ref_acc} + 17'(REF_CLOCK_KHZ);
	end
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			ref_acc  <= 16'h0000;
			ref_tick <= 1'b0;
		end else if (I_CE) begin
			if (next_ref_acc >= 17'd50000) begin
				ref_acc  <= 16'(next_ref_acc - 17'd50000); // [RULE12]
				ref_tick <= 1'b1;
			end else begin
				ref_acc  <= next_ref_acc[15:0];
				ref_tick <= 1'b0;
			end
		end
	end

	logic [DIV_TAPS-1:0] taps;
	fdc_clock_divider #(
		.TAPS(DIV_TAPS)
	) u_div (
		.i_clk     (I_CLOCK),
		.i_rst_n   (I_RST_N),
		.i_ce      (I_CE),
		.i_ref_tick(ref_tick),
		.o_taps    (taps)
	);

	// Taps: 0=8M 1=4M 2=2M 3=1M 4=500k 5=250k
	function automatic logic [1:0] mux_pick(input logic [DIV_TAPS-1:0] t, input logic dd, input logic sm_n);
		case ({sm_n, dd})
			2'b01:   mux_pick = {t[1], t[4]};
			2'b00:   mux_pick = {t[2], t[5]};
			2'b11:   mux_pick = {t[0], t[3]};
			default: mux_pick = {t[1], t[4]};
		endcase
	endfunction

	logic [1:0] mux_out;
	logic       wsrc_d;
	logic [3:0] wpulse_cnt;
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			mux_out      <= 2'b00;
			O_REF_CLOCK  <= 1'b0;
			O_CHIP_CLOCK <= 1'b0;
			O_WCLK_SOURCE <= 1'b0;
		end else if (I_CE) begin
			mux_out       <= mux_pick(taps, dbl_density, small_drive_n); // [RULE14] [RULE15]
			O_REF_CLOCK   <= taps[0];
			O_CHIP_CLOCK  <= mux_out[1];
			O_WCLK_SOURCE <= mux_out[0];
		end
	end

	// Write clock: fixed-width pulse on each rising edge of the slow mux output
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			wsrc_d              <= 1'b0;
			wpulse_cnt          <= 4'h0;
			O_WRITE_CLOCK_PULSE <= 1'b0;
		end else if (I_CE) begin
			wsrc_d <= mux_out[0];
			if (mux_out[0] && !wsrc_d) begin
				wpulse_cnt          <= 4'(WCLK_PULSE_CYCLES - 1); // [RULE16]
				O_WRITE_CLOCK_PULSE <= 1'b1;
			end else if (wpulse_cnt != 4'h0) begin
				wpulse_cnt          <= wpulse_cnt - 4'h1;
				O_WRITE_CLOCK_PULSE <= 1'b1;
			end else begin
				O_WRITE_CLOCK_PULSE <= 1'b0;
			end
		end
	end

	// Data separator: a stream edge outside the bit window is clock and restarts it; an edge inside the window is data
	logic       stream_d;
	logic [4:0] sep_cnt;
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			stream_d    <= 1'b0;
			sep_cnt     <= 5'h00;
			O_SEP_CLOCK <= 1'b0;
			O_SEP_DATA  <= 1'b0;
		end else if (I_CE) begin
			stream_d    <= read_stream;
			O_SEP_CLOCK <= 1'b0;
			O_SEP_DATA  <= 1'b0;
			if (read_stream && !stream_d) begin
				if (sep_cnt == 5'h00 || sep_cnt >= 5'(SEP_WINDOW_CYCLES)) begin
					O_SEP_CLOCK <= 1'b1; // [RULE19]
					sep_cnt     <= 5'h01;
				end else begin
					O_SEP_DATA  <= 1'b1; // [RULE19]
				end
			end else if (sep_cnt != 5'h00 && sep_cnt < 5'h1f) begin
				sep_cnt <= sep_cnt + 5'h01;
			end
		end
	end

endmodule

// ---- dv/fdc_host_model.sv ----
// Purpose: Host adapter side that drives the busy and transfer direction lines
// Assumes: The mode changes at most once per test step
// Notes:   The lines change shortly after the clock edge
`timescale 1ns/1ps
module fdc_host_model (
	// Clock and mode
	input  wire logic       i_clk,
	input  wire logic [1:0] i_mode,
	// Host bus lines
	output logic            o_busy,
	output logic            o_to_dev
);
	// Direction low: controller sends, high: host sends; mode taken at the edge, driven 2 ns later
	always @(posedge i_clk) {o_busy, o_to_dev} <= #2 i_mode;
endmodule

// ---- dv/fdc_board_glue_properties.sv ----
// Purpose: Port assertions of the floppy board glue
// Assumes: Checks pause while I_CE is low
// Notes:   Decode outputs follow inputs that stood for four samples
`timescale 1ns/1ps
module fdc_board_glue_checker
	import fdc_glue_pkg::*;
(
	// Watched inputs
	input wire logic        I_CLOCK, I_RST_N, I_CE, I_CPU_READ, I_CPU_PHASE_B,
	input wire logic        I_HOST_BUSY, I_HOST_TO_DEV, I_DISK_CHIP_IRQ,
	input wire logic [15:0] I_ADDR,
	// Watched outputs
	input wire logic        O_RAM_SELECT_N, O_ROM_SELECT_N, O_OUT_BYTE_CLOCK_N, O_IN_BYTE_ENABLE_N,
	input wire logic        O_OUT_DRIVER_ENABLE_N, O_HOST_STAT_ENABLE_N, O_HOST_CMD_CLOCK_N,
	input wire logic        O_LAST_BYTE_N, O_DISK_CHIP_SELECT_N, O_READ_N, O_WRITE_N, O_CPU_IRQ_N,
	input wire logic        O_WRITE_CLOCK_PULSE
);
	wire p = I_CPU_PHASE_B;
	wire r = I_CPU_READ;
	wire a1 = I_ADDR == HOST_BYTE_ADDR;
	wire a0 = I_ADDR == HOST_CMD_STAT_ADDR;
	wire hd = I_HOST_BUSY && I_HOST_TO_DEV;
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N || !I_CE);
	// Consecutive high samples of the write clock, frozen with the enable
	int wclk_run;
	always_ff @(posedge I_CLOCK) begin
		if (!I_RST_N) begin
			wclk_run <= 0;
		end else if (I_CE) begin
			wclk_run <= O_WRITE_CLOCK_PULSE ? wclk_run + 1 : 0;
		end
	end
	chk_ram_sel: assert property ((I_ADDR[15:11] == 5'h00)[*4] |-> !O_RAM_SELECT_N) else $error("ram select");
	chk_rom_sel: assert property ((&I_ADDR[15:12])[*4] |-> !O_ROM_SELECT_N) else $error("rom select");
	chk_out_clk: assert property (a1[*4] |-> !O_OUT_BYTE_CLOCK_N) else $error("out clock");
	chk_in_en: assert property ((a1 && p && !I_HOST_TO_DEV)[*4] |-> !O_IN_BYTE_ENABLE_N) else $error("in en");
	chk_drv_on: assert property (hd[*4] |-> !O_OUT_DRIVER_ENABLE_N) else $error("driver on");
	chk_drv_off: assert property ((!hd)[*4] |-> O_OUT_DRIVER_ENABLE_N) else $error("driver off");
	chk_stat_en: assert property ((a0 && r && p)[*4] |-> !O_HOST_STAT_ENABLE_N) else $error("status");
	chk_cmd_clk: assert property ((a0 && !r && p)[*4] |-> !O_HOST_CMD_CLOCK_N) else $error("command");
	chk_last_byte: assert property ((I_ADDR == LAST_BYTE_ADDR && p)[*4] |-> !O_LAST_BYTE_N) else $error("last");
	chk_disk_sel: assert property (((I_ADDR == DISK_CTRL_ADDR || I_ADDR == DISK_STAT_ADDR) && p)[*4]
		|-> !O_DISK_CHIP_SELECT_N) else $error("disk select");
	chk_read_stb: assert property ((r && p)[*4] |-> !O_READ_N && O_WRITE_N) else $error("read");
	chk_write_stb: assert property ((!r && p)[*4] |-> O_READ_N && !O_WRITE_N) else $error("write");
	chk_no_stb: assert property ((!p)[*4] |-> O_READ_N && O_WRITE_N) else $error("idle strobe");
	chk_irq_pass: assert property (I_DISK_CHIP_IRQ[*4] |-> !O_CPU_IRQ_N) else $error("irq");
	chk_wclk_width: assert property ($fell(O_WRITE_CLOCK_PULSE) |-> wclk_run == WCLK_PULSE_CYCLES)
		else $error("write pulse width");
	chk_wclk_max: assert property (wclk_run <= WCLK_PULSE_CYCLES)
		else $error("write pulse too long");
endmodule
bind fdc_board_glue fdc_board_glue_checker u_chk (.*);

// ---- dv/fdc_board_glue_tb_top.sv ----
// Purpose: Self-checking bench of the floppy board glue
// Assumes: Inputs change 2 ns after the rising clock edge
// Notes:   Decode sweep, enable freeze, clock tap counts in all strap modes, separator bits
`timescale 1ns/1ps
module fdc_board_glue_tb_top;
	import fdc_glue_pkg::*;
	logic        I_CLOCK = 0, I_RST_N = 0, I_CE = 1, I_CPU_READ = 0, I_CPU_PHASE_B = 0, I_DISK_CHIP_IRQ = 0;
	logic        I_DOUBLE_DENSITY_SEL = 1, I_SMALL_DRIVE_SEL_N = 0, I_READ_STREAM = 0;
	logic [15:0] I_ADDR = 16'h0000;
	logic [1:0]  host_mode = 2'h0;
	wire logic   I_HOST_BUSY, I_HOST_TO_DEV;
	logic        O_RAM_SELECT_N, O_ROM_SELECT_N, O_OUT_BYTE_CLOCK_N, O_IN_BYTE_ENABLE_N, O_OUT_DRIVER_ENABLE_N;
	logic        O_HOST_STAT_ENABLE_N, O_HOST_CMD_CLOCK_N, O_LAST_BYTE_N, O_DISK_CHIP_SELECT_N, O_READ_N;
	logic        O_WRITE_N, O_CPU_IRQ_N, O_REF_CLOCK, O_CHIP_CLOCK, O_WCLK_SOURCE, O_WRITE_CLOCK_PULSE;
	logic        O_SEP_CLOCK, O_SEP_DATA;
	int          err_count = 0, samples_checked = 0;
	logic [15:0] snap;
	localparam int SEP_CELL      = SEP_WINDOW_CYCLES + 4;
	localparam int SEP_CELL_DATA = SEP_WINDOW_CYCLES / 2;
	logic [15:0] addrs [12] = '{16'h0000, 16'h07ff, 16'h0800, 16'h0801, 16'h0802, 16'h0803, 16'h0804,
		16'h0805, 16'h0806, 16'h1000, 16'hf000, 16'hffff};
	wire [11:0]  dec = {O_RAM_SELECT_N, O_ROM_SELECT_N, O_OUT_BYTE_CLOCK_N, O_IN_BYTE_ENABLE_N,
		O_OUT_DRIVER_ENABLE_N, O_HOST_STAT_ENABLE_N, O_HOST_CMD_CLOCK_N, O_LAST_BYTE_N,
		O_DISK_CHIP_SELECT_N, O_READ_N, O_WRITE_N, O_CPU_IRQ_N};
	fdc_board_glue u_dut (.*);
	fdc_host_model u_host (.i_clk(I_CLOCK), .i_mode(host_mode), .o_busy(I_HOST_BUSY), .o_to_dev(I_HOST_TO_DEV));
	// Selects are active low, so the expectation is inverted as a whole
	function automatic logic [11:0] exp_dec(logic [15:0] a, logic r, logic p, logic b, logic d, logic q);
		return ~{a[15:11] == 5'h00, &a[15:12], a == HOST_BYTE_ADDR, a == HOST_BYTE_ADDR && p && !d, b && d,
			a == HOST_CMD_STAT_ADDR && r && p, a == HOST_CMD_STAT_ADDR && !r && p, a == LAST_BYTE_ADDR && p,
			(a == DISK_CTRL_ADDR || a == DISK_STAT_ADDR) && p, r && p, !r && p, q};
	endfunction
	task check(string n, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task measure(logic [1:0] m, int ec, int ew);
		int         cnt [4];
		int         e [4];
		logic [3:0] now, prev;
		e = '{320, ec, ew, ew};
		cnt = '{0, 0, 0, 0};
		{I_SMALL_DRIVE_SEL_N, I_DOUBLE_DENSITY_SEL} = m;
		repeat (40) @(posedge I_CLOCK);
		#2 prev = {O_WRITE_CLOCK_PULSE, O_WCLK_SOURCE, O_CHIP_CLOCK, O_REF_CLOCK};
		repeat (2000) begin
			@(posedge I_CLOCK);
			#2 now = {O_WRITE_CLOCK_PULSE, O_WCLK_SOURCE, O_CHIP_CLOCK, O_REF_CLOCK};
			for (int j = 0; j < 4; j++) cnt[j] += int'(now[j] && !prev[j]);
			prev = now;
		end
		for (int j = 0; j < 4; j++) check("clock tap rise count", 1, cnt[j] >= e[j] - 1 && cnt[j] <= e[j] + 1);
	endtask
	// Each cell: clock bit at its start, data bit mid-window when set
	task sep_run(logic [7:0] bits);
		int cc;
		int dc;
		int s;
		cc = 0;
		dc = 0;
		for (int c = 0; c < 8 * SEP_CELL + 40; c++) begin
			@(posedge I_CLOCK);
			#2 cc += O_SEP_CLOCK;
			dc += O_SEP_DATA;
			s = c % SEP_CELL;
			I_READ_STREAM = c < 8 * SEP_CELL && (s < 2 ||
				(s >= SEP_CELL_DATA && s < SEP_CELL_DATA + 2 && bits[7 - c / SEP_CELL]));
		end
		check("separated clock bits", 8, cc);
		check("separated data bits", $countones(bits), dc);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial forever #10 I_CLOCK = ~I_CLOCK;
	initial begin
		#1000000;
		err_count++;
		final_report;
	end
	initial begin
		repeat (12) @(posedge I_CLOCK);
		#2 I_RST_N = 1;
		for (int i = 0; i < 12; i++) for (int k = 0; k < 16; k++) begin
			@(posedge I_CLOCK);
			#2 I_ADDR = addrs[i];
			{I_CPU_READ, I_CPU_PHASE_B} = k[1:0];
			host_mode = k[3:2];
			I_DISK_CHIP_IRQ = k[0] ^ k[3];
			repeat (6) @(posedge I_CLOCK);
			#2 check("decode outputs", exp_dec(addrs[i], k[1], k[0], k[3], k[2], k[0] ^ k[3]), dec);
		end
		// Enable low freezes decode and clocks while the inputs move
		{I_CPU_READ, I_CPU_PHASE_B} = 2'b11;
		host_mode = 2'h0;
		I_DISK_CHIP_IRQ = 1'b0;
		repeat (6) @(posedge I_CLOCK);
		#2 I_CE = 1'b0;
		snap = {dec, O_REF_CLOCK, O_CHIP_CLOCK, O_WCLK_SOURCE, O_WRITE_CLOCK_PULSE};
		I_ADDR = HOST_CMD_STAT_ADDR;
		I_DISK_CHIP_IRQ = 1'b1;
		repeat (20) @(posedge I_CLOCK);
		#2 check("frozen outputs", snap, {dec, O_REF_CLOCK, O_CHIP_CLOCK, O_WCLK_SOURCE, O_WRITE_CLOCK_PULSE});
		I_CE = 1'b1;
		repeat (6) @(posedge I_CLOCK);
		#2 check("decode after enable", exp_dec(HOST_CMD_STAT_ADDR, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1), dec);
		measure(2'b01, 160, 20);
		measure(2'b00, 80, 10);
		measure(2'b11, 320, 40);
		measure(2'b10, 160, 20);
		sep_run(8'hb5);
		sep_run(8'h4e);
		final_report;
	end
endmodule
